// File: pkg/xwf_pkg.sv
package xwf_pkg;
    // ************************************************************
    // Opcode fields, address limits and reset values
    // ************************************************************
    localparam logic [5:0]  OPC_XOR_WF    = 6'h06;
    localparam int          OPC_HI        = 15;
    localparam int          OPC_LO        = 10;
    localparam int          DEST_BIT      = 9;
    localparam int          ACC_BIT       = 8;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
    localparam logic [7:0]  ACC_SPLIT     = 8'h60;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0]  W_RESET       = 8'h00;
    localparam logic [11:0] ADDR_RESET    = 12'h000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        XWF_Q1 = 4'h1,
        XWF_Q2 = 4'h2,
        XWF_Q3 = 4'h4,
        XWF_Q4 = 4'h8
    } xwf_phase_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } xwf_mem_req_t;

    typedef struct packed {
        logic n;
        logic z;
    } xwf_flags_t;
endpackage

// File: core/xwf_core.sv
`timescale 1ns/10ps
// Function
// - Decode opcode 000110da ffffffff as xor
// - Destination zero writes result to working register
// - Destination one writes result to file register
// - Access zero resolves address in access bank
// - Access one prefixes address with bank select
// - Extended, access zero, f<=95: indexed literal offset
module xwf_core
    import xwf_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [15:0]  opcode,
    input  wire logic         ext_mode,
    input  wire logic [3:0]   bank_select_reg,
    input  wire logic [11:0]  index_base,
    input  wire logic [7:0]   mem_rdata,
    output xwf_mem_req_t      mem_req,
    output logic [7:0]        work_reg,
    output xwf_flags_t        flags,
    output logic              busy,
    output logic              done
);
    // ************************************************************
    // Phase sequencer
    // ************************************************************
    xwf_phase_t   ph_q, ph_d;
    logic         hit_q, hit_d, dst_q, dst_d;
    logic [11:0]  addr_q, addr_d;
    logic [7:0]   res_q, res_d, w_q, w_d;
    xwf_flags_t   fl_q, fl_d;
    xwf_mem_req_t req_q, req_d;
    logic         done_q, done_d;
    logic         is_xor;
    logic [11:0]  ea;
    logic [7:0]   f;

    // ************************************************************
    // Address resolution
    // ************************************************************
    assign f      = opcode[7:0];
    assign is_xor = (opcode[OPC_HI:OPC_LO] == OPC_XOR_WF);

    always_comb begin
        if (opcode[ACC_BIT]) begin
            ea = {bank_select_reg, f};
        end else if (ext_mode && f <= IDX_LIMIT) begin
            ea = index_base + {4'h0, f};
        end else if (f < ACC_SPLIT) begin
            ea = {4'h0, f};
        end else begin
            ea = {ACC_HIGH_BANK, f};
        end
    end

    always_comb begin
        ph_d   = ph_q;
        hit_d  = hit_q;
        dst_d  = dst_q;
        addr_d = addr_q;
        res_d  = res_q;
        w_d    = w_q;
        fl_d   = fl_q;
        req_d  = '0;
        done_d = 1'b0;
        case (ph_q)
            XWF_Q1: begin
                hit_d  = is_xor;
                dst_d  = opcode[DEST_BIT];
                addr_d = ea;
                ph_d   = XWF_Q2;
                if (is_xor) begin
                    req_d.addr = ea;
                    req_d.re   = 1'b1;
                end
            end
            XWF_Q2: begin
                if (hit_q) begin
                    res_d = w_q ^ mem_rdata;
                end
                ph_d = XWF_Q3;
            end
            XWF_Q3: begin
                if (hit_q) begin
                    fl_d.n = res_q[7];
                    fl_d.z = (res_q == 8'h00);
                    if (dst_q) begin
                        req_d.addr  = addr_q;
                        req_d.wdata = res_q;
                        req_d.we    = 1'b1;
                    end else begin
                        w_d = res_q;
                    end
                    done_d = 1'b1;
                end
                ph_d = XWF_Q4;
            end
            XWF_Q4: begin
                ph_d = XWF_Q1;
            end
            default: begin
                ph_d = XWF_Q1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q   <= XWF_Q1;
            hit_q  <= 1'b0;
            dst_q  <= 1'b0;
            addr_q <= ADDR_RESET;
            res_q  <= W_RESET;
            w_q    <= W_RESET;
            fl_q   <= '0;
            req_q  <= '0;
            done_q <= 1'b0;
        end else begin
            ph_q   <= ph_d;
            hit_q  <= hit_d;
            dst_q  <= dst_d;
            addr_q <= addr_d;
            res_q  <= res_d;
            w_q    <= w_d;
            fl_q   <= fl_d;
            req_q  <= req_d;
            done_q <= done_d;
        end
    end

    // Request registered, so it shows in the phase after it is formed
    assign mem_req  = req_q;
    assign work_reg = w_q;
    assign flags    = fl_q;
    assign done     = done_q;
    assign busy     = hit_q && (ph_q != XWF_Q1);

    // ************************************************************
    // Checks
    // ************************************************************
    a_phase_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q1 |=> ph_q == XWF_Q2 ##1 ph_q == XWF_Q3
        ##1 ph_q == XWF_Q4)
        else $error("phase order broken");

    a_read_issue: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q1 && is_xor
        |=> mem_req.re && mem_req.addr == $past(ea))
        else $error("read not issued");

    a_no_decode: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q1 && !is_xor
        |=> !mem_req.re ##2 !mem_req.we && !done)
        else $error("foreign opcode acted on");

    a_xor_result: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q3 && hit_q
        |-> res_q == ($past(w_q) ^ $past(mem_rdata)))
        else $error("xor result wrong");

    a_dest_w: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q3 && hit_q && !dst_q
        |=> w_q == $past(res_q) && !mem_req.we)
        else $error("w destination wrong");

    a_dest_f: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q3 && hit_q && dst_q
        |=> mem_req.we && mem_req.wdata == $past(res_q)
        && mem_req.addr == $past(addr_q) && $stable(w_q))
        else $error("f destination wrong");

    a_acc_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        !opcode[ACC_BIT] && !ext_mode && f < ACC_SPLIT
        |-> ea == {4'h0, f})
        else $error("access bank low wrong");

    a_acc_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        !opcode[ACC_BIT] && !ext_mode && f >= ACC_SPLIT
        |-> ea == {ACC_HIGH_BANK, f})
        else $error("access bank high wrong");

    a_bank_sel: assert property (
        @(posedge clk) disable iff (!rst_n)
        opcode[ACC_BIT]
        |-> ea == {bank_select_reg, f})
        else $error("bank select ignored");

    a_index_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        !opcode[ACC_BIT] && ext_mode && f <= IDX_LIMIT
        |-> ea == index_base + {4'h0, f})
        else $error("indexed offset wrong");

    // Flags are held against the byte actually written, not the xor result
    a_flag_z: assert property (
        @(posedge clk) disable iff (!rst_n)
        done
        |-> flags.z == ((dst_q ? mem_req.wdata : w_q) == 8'h00))
        else $error("zero flag wrong");

    a_flag_n: assert property (
        @(posedge clk) disable iff (!rst_n)
        done
        |-> flags.n == (dst_q ? mem_req.wdata[7] : w_q[7]))
        else $error("negative flag wrong");

    a_done_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        done
        |=> !done)
        else $error("done longer than one cycle");

    a_re_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.re
        |=> !mem_req.re)
        else $error("read longer than one cycle");

    a_busy_span: assert property (
        @(posedge clk) disable iff (!rst_n)
        ph_q == XWF_Q1 && is_xor
        |=> busy [*3] ##1 !busy)
        else $error("busy span wrong");
endmodule

// File: tb/xwf_mem_model.sv
`timescale 1ns/10ps
module xwf_mem_model
    import xwf_pkg::*;
(
    input  wire logic         clk,
    input  wire xwf_mem_req_t mem_req,
    output logic [7:0]        mem_rdata
);
    // ********
    // Data memory
    // ********
    logic [7:0] mem [4096];
    logic [7:0] last_q = 8'h00;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ i[11:4];
        end
    end
    // Idle bus shows the inverse of the last byte so stale data never passes
    assign mem_rdata = mem_req.re ? mem[mem_req.addr] : ~last_q;
    always @(posedge clk) begin
        if (mem_req.re)
            last_q <= mem[mem_req.addr];
        if (mem_req.we)
            mem[mem_req.addr] <= mem_req.wdata;
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench
    import xwf_pkg::*;
();
    // ********
    // Stimulus and scoreboard
    // ********
    typedef struct packed {
        logic [11:0] ea;
        logic        d;
        logic [7:0]  res;
    } xwf_note_t;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ext_mode = 1'b0;
    logic [15:0]  opcode = 16'h0000;
    logic [3:0]   bank_select_reg = 4'h0;
    logic [11:0]  index_base = 12'h000;
    logic [7:0]   mem_rdata;
    logic [7:0]   work_reg;
    logic [7:0]   w_exp = 8'h00;
    xwf_mem_req_t mem_req;
    xwf_flags_t   flags;
    logic         busy;
    logic         done;
    logic [7:0]   shadow [4096];
    logic [31:0]  seed = 32'h88d0;
    logic [31:0]  r;
    logic [15:0]  op;
    xwf_note_t    nt;
    xwf_note_t    notes [$];
    int           miscompares = 0;
    int           checks_done = 0;
    always #25 clk = ~clk;
    xwf_core xwf_core_inst (.clk(clk), .rst_n(rst_n), .opcode(opcode),
        .ext_mode(ext_mode), .bank_select_reg(bank_select_reg),
        .index_base(index_base), .mem_rdata(mem_rdata), .mem_req(mem_req),
        .work_reg(work_reg), .flags(flags), .busy(busy), .done(done));
    xwf_mem_model xwf_mem_model_inst (.clk(clk), .mem_req(mem_req),
        .mem_rdata(mem_rdata));
    initial begin
        for (int i = 0; i < 4096; i++) begin
            shadow[i] = i[7:0] ^ i[11:4];
        end
    end
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic [15:0] o, input logic x,
                         input logic [3:0] b, input logic [11:0] ib);
        xwf_note_t n;
        logic [7:0] f;
        f = o[7:0];
        opcode <= o;
        ext_mode <= x;
        bank_select_reg <= b;
        index_base <= ib;
        if (o[OPC_HI:OPC_LO] === OPC_XOR_WF) begin
            if (o[ACC_BIT])
                n.ea = {b, f};
            else if (x && f <= IDX_LIMIT)
                n.ea = ib + {4'h0, f};
            else if (f < ACC_SPLIT)
                n.ea = {4'h0, f};
            else
                n.ea = {ACC_HIGH_BANK, f};
            n.d = o[DEST_BIT];
            n.res = w_exp ^ shadow[n.ea];
            if (n.d)
                shadow[n.ea] = n.res;
            else
                w_exp = n.res;
            notes.push_back(n);
        end
        repeat (4) @(posedge clk);
    endtask
    always @(negedge clk) begin
        if (rst_n && notes.size() == 0)
            check(12'(busy), 12'h000);
        if (rst_n && mem_req.re === 1'b1) begin
            check(12'(notes.size() != 0), 12'h001);
            check(12'(busy), 12'h001);
            if (notes.size() != 0)
                check(mem_req.addr, notes[0].ea);
        end
        if (rst_n && (done === 1'b1 || mem_req.we === 1'b1)) begin
            check(12'(notes.size() != 0), 12'h001);
            if (notes.size() != 0) begin
                nt = notes.pop_front();
                check(12'(done), 12'h001);
                check(12'(mem_req.we), 12'(nt.d));
                if (nt.d) begin
                    check(mem_req.addr, nt.ea);
                    check(12'(mem_req.wdata), 12'(nt.res));
                    check(12'(work_reg), 12'(w_exp));
                end else begin
                    check(12'(work_reg), 12'(nt.res));
                end
                check(12'(flags), 12'({nt.res[7], nt.res == 8'h00}));
            end
        end
    end
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        @(posedge clk);
        @(negedge clk);
        check(12'({mem_req.we, mem_req.re, done, busy}), 12'h000);
        check(12'(work_reg), 12'(W_RESET));
        check(12'(flags), 12'h000);
        @(posedge clk);
        rst_n <= 1'b1;
        issue(16'h1a5f, 1'b1, 4'h3, 12'hff0);
        issue(16'h1a60, 1'b1, 4'h3, 12'h123);
        issue(16'h185f, 1'b0, 4'h3, 12'h123);
        issue(16'h1bff, 1'b0, 4'h3, 12'h123);
        issue(16'h1e5f, 1'b1, 4'h3, 12'h123);
        $display("test boundaries done");
        for (int i = 0; i < 300; i++) begin
            r = xorshift();
            op = r[15:0];
            if (i % 6 != 0)
                op[OPC_HI:OPC_LO] = OPC_XOR_WF;
            issue(op, r[16], r[20:17], r[31:20]);
        end
        $display("test random done");
        for (int i = 0; i < 8 && notes.size() > 0; i++) @(posedge clk);
        if (notes.size() > 0)
            miscompares++;
        print_verdict();
    end
endmodule
